// File: src/fmc_edge_if.sv
// Interface carrying synchronised pin levels and one-cycle edge pulses.
// Assumes producer and consumer share the counter clock.
`timescale 1ns/1ps
interface fmc_edge_if #(
	parameter int N_CH = 4
);
	logic [N_CH-1:0] lvl;
	logic [N_CH-1:0] rise;
	logic [N_CH-1:0] fall;

	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface : fmc_edge_if

// File: src/fmc_edge_sync.sv
// Two-flop synchroniser bank with rise and fall detection on the second stage.
// Assumes asynchronous pins and one counter clock.
`timescale 1ns/1ps
module fmc_edge_sync #(
	parameter int N_CH = 4
) (
	input  wire logic            i_mclk,
	input  wire logic            i_reset,
	input  wire logic [N_CH-1:0] i_pins,
	fmc_edge_if.src              edges
);
	logic [N_CH-1:0] meta_reg;
	logic [N_CH-1:0] meta_next;
	logic [N_CH-1:0] sync_reg;
	logic [N_CH-1:0] sync_next;
	logic [N_CH-1:0] prev_reg;
	logic [N_CH-1:0] prev_next;

	always_comb begin
		meta_next = i_pins;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// Edges look only at the second stage and its delayed copy
	assign edges.lvl  = sync_reg;
	assign edges.rise = sync_reg & ~prev_reg;
	assign edges.fall = ~sync_reg & prev_reg;
endmodule // fmc_edge_sync

// File: src/fmc_pkg.sv
// Package of the frequency measure counter: mode codes, input channel map, reset values.
// Assumes every user of it imports the whole package.
package fmc_pkg;

	// Measurement methods, one-hot
	typedef enum logic [3:0] {
		FMC_MODE_ONE = 4'h1,
		FMC_MODE_HF  = 4'h2,
		FMC_MODE_LR  = 4'h4,
		FMC_MODE_SC  = 4'h8
	} fmc_mode_t;

	// Configuration select codes on the mode input
	localparam logic [1:0] FMC_SEL_ONE = 2'h0;
	localparam logic [1:0] FMC_SEL_HF  = 2'h1;
	localparam logic [1:0] FMC_SEL_LR  = 2'h2;
	localparam logic [1:0] FMC_SEL_SC  = 2'h3;

	// Positions of the pins in the synchroniser bank
	localparam int FMC_N_CH        = 4;
	localparam int FMC_CH_SIGNAL   = 0;
	localparam int FMC_CH_TIMEBASE = 1;
	localparam int FMC_CH_SAMPLE   = 2;
	localparam int FMC_CH_GATE     = 3;

	// Reset values of the configuration
	localparam fmc_mode_t   FMC_RST_MODE     = FMC_MODE_ONE;
	localparam logic        FMC_RST_AVG      = 1'b1;
	localparam logic        FMC_RST_EXT_GATE = 1'b0;
	localparam logic [31:0] FMC_RST_DIV_N    = 32'h0000_0010;
	localparam logic [31:0] FMC_RST_GATE_LEN = 32'h0000_03E8;

endpackage : fmc_pkg

// File: src/fmc_top.sv
// Frequency measure counter: one-counter, high-frequency, large-range and sample-clocked methods.
// Assumes pins are asynchronous to i_mclk and configuration comes from logic on i_mclk.
// Function
// - Non-averaging sample mode returns the last complete input period before each sample clock.
// - One-counter mode counts timebase ticks over exactly one input period.
// - High-frequency mode: gate counter (or the external gate when selected) makes gate, measuring counter counts input edges.
// - Internal high-frequency gate lasts the configured time, so each result takes fixed time; an external gate ends at its falling edge.
// - Large-range mode divides input by N and times one divided period.
// - Sample mode counts timebase ticks over each sample clock period.
// - Averaging counts input ticks beside timebase ticks each sample period.
// - Averaging is enabled by default.
// - Counter pairs are fixed: measuring counter with its own gate counter.
`timescale 1ns/1ps
module fmc_top
	import fmc_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input  wire logic             i_mclk,
	input  wire logic             i_reset,
	input  wire logic             i_signal,
	input  wire logic             i_timebase,
	input  wire logic             i_sample_clk,
	input  wire logic             i_ext_gate,
	input  wire logic             i_cfg_load,
	input  wire logic [1:0]       i_cfg_mode,
	input  wire logic             i_cfg_ext_gate,
	input  wire logic             i_averaging_enable,
	input  wire logic [CNT_W-1:0] i_cfg_div_n,
	input  wire logic [CNT_W-1:0] i_cfg_gate_len,
	output logic [CNT_W-1:0]      o_count_primary,
	output logic [CNT_W-1:0]      o_count_embedded,
	output logic                  o_valid,
	output logic                  o_overflow,
	output logic                  o_gate
);
	if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
		$error("CNT_W must lie between 8 and 32");
	end

	fmc_edge_if #(.N_CH(FMC_N_CH)) edges ();

	fmc_edge_sync #(.N_CH(FMC_N_CH)) u_sync (
		.i_mclk (i_mclk),
		.i_reset(i_reset),
		.i_pins ({i_ext_gate, i_sample_clk, i_timebase, i_signal}),
		.edges  (edges.src)
	);

	function automatic logic [CNT_W-1:0] add_bit(input logic [CNT_W-1:0] v, input logic b);
		return v + {{(CNT_W-1){1'b0}}, b};
	endfunction

	function automatic fmc_mode_t decode_mode(input logic [1:0] sel);
		fmc_mode_t m;
		m = FMC_MODE_ONE;
		unique case (sel)
			FMC_SEL_ONE: m = FMC_MODE_ONE;
			FMC_SEL_HF:  m = FMC_MODE_HF;
			FMC_SEL_LR:  m = FMC_MODE_LR;
			FMC_SEL_SC:  m = FMC_MODE_SC;
		endcase
		return m;
	endfunction

	logic sig_rise;
	logic tb_rise;
	logic smp_rise;
	logic gate_lvl;
	logic gate_fall;
	assign sig_rise  = edges.rise[FMC_CH_SIGNAL];
	assign tb_rise   = edges.rise[FMC_CH_TIMEBASE];
	assign smp_rise  = edges.rise[FMC_CH_SAMPLE];
	assign gate_lvl  = edges.lvl[FMC_CH_GATE];
	assign gate_fall = edges.fall[FMC_CH_GATE];

	// Configuration
	fmc_mode_t        mode_reg,         mode_next;
	logic             avg_reg,          avg_next;
	logic             ext_reg,          ext_next;
	logic [CNT_W-1:0] div_n_reg,        div_n_next;
	logic [CNT_W-1:0] gate_len_reg,     gate_len_next;
	// Measurement state
	logic [CNT_W-1:0] prim_reg,         prim_next;
	logic [CNT_W-1:0] emb_reg,          emb_next;
	logic [CNT_W-1:0] gate_cnt_reg,     gate_cnt_next;
	logic [CNT_W-1:0] div_cnt_reg,      div_cnt_next;
	logic [CNT_W-1:0] per_reg,          per_next;
	logic [CNT_W-1:0] last_per_reg,     last_per_next;
	logic             armed_reg,        armed_next;
	logic             per_armed_reg,    per_armed_next;
	logic             seen_reg,         seen_next;
	// Outputs
	logic [CNT_W-1:0] out_prim_reg,     out_prim_next;
	logic [CNT_W-1:0] out_emb_reg,      out_emb_next;
	logic             valid_reg,        valid_next;
	logic             ovf_reg,          ovf_next;
	logic             gate_reg,         gate_next;

	logic [CNT_W-1:0] prim_inc;
	logic [CNT_W-1:0] per_inc;
	logic             hf_end;
	logic             div_edge;
	logic             per_done;

	assign prim_inc = add_bit(prim_reg, tb_rise);
	assign per_inc  = add_bit(per_reg, tb_rise);
	// Internal gate closes on the timebase tick that completes the configured length
	assign hf_end   = ext_reg ? gate_fall : (tb_rise && gate_cnt_reg == gate_len_reg - 1'b1);
	assign div_edge = sig_rise && div_cnt_reg == div_n_reg - 1'b1;
	assign per_done = sig_rise && per_armed_reg;

	always_comb begin
		mode_next      = mode_reg;
		avg_next       = avg_reg;
		ext_next       = ext_reg;
		div_n_next     = div_n_reg;
		gate_len_next  = gate_len_reg;
		prim_next      = prim_reg;
		emb_next       = emb_reg;
		gate_cnt_next  = gate_cnt_reg;
		div_cnt_next   = div_cnt_reg;
		per_next       = per_reg;
		last_per_next  = last_per_reg;
		armed_next     = armed_reg;
		per_armed_next = per_armed_reg;
		seen_next      = seen_reg;
		out_prim_next  = out_prim_reg;
		out_emb_next   = out_emb_reg;
		valid_next     = 1'b0;
		ovf_next       = 1'b0;
		gate_next      = 1'b0;
		if (i_cfg_load) begin
			// New configuration restarts every measurement
			mode_next      = decode_mode(i_cfg_mode);
			avg_next       = i_averaging_enable;
			ext_next       = i_cfg_ext_gate;
			div_n_next     = (i_cfg_div_n == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : i_cfg_div_n;
			gate_len_next  = (i_cfg_gate_len == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : i_cfg_gate_len;
			prim_next      = '0;
			emb_next       = '0;
			gate_cnt_next  = '0;
			div_cnt_next   = '0;
			per_next       = '0;
			armed_next     = 1'b0;
			per_armed_next = 1'b0;
			seen_next      = 1'b0;
		end else begin
			unique case (mode_reg)
				FMC_MODE_ONE: begin
					prim_next = prim_inc;
					if (sig_rise) begin
						if (armed_reg) begin
							out_prim_next = prim_inc;
							out_emb_next  = {{(CNT_W-1){1'b0}}, 1'b1};
							valid_next    = 1'b1;
						end
						armed_next = 1'b1;
						prim_next  = '0;
					end
				end
				FMC_MODE_HF: begin
					if (ext_reg) begin
						// External gate of known width replaces the gate counter
						if (gate_lvl) begin
							emb_next = add_bit(emb_reg, sig_rise);
						end
					end else begin
						emb_next  = add_bit(emb_reg, sig_rise);
						gate_next = 1'b1;
						if (tb_rise) begin
							gate_cnt_next = gate_cnt_reg + 1'b1;
						end
					end
					if (hf_end) begin
						out_prim_next = gate_len_reg;
						out_emb_next  = ext_reg ? emb_reg : add_bit(emb_reg, sig_rise);
						valid_next    = 1'b1;
						emb_next      = '0;
						gate_cnt_next = '0;
						gate_next     = 1'b0;
					end
				end
				FMC_MODE_LR: begin
					prim_next = prim_inc;
					if (sig_rise) begin
						div_cnt_next = div_edge ? '0 : div_cnt_reg + 1'b1;
					end
					if (div_edge) begin
						if (armed_reg) begin
							out_prim_next = prim_inc;
							out_emb_next  = div_n_reg;
							valid_next    = 1'b1;
						end
						armed_next = 1'b1;
						prim_next  = '0;
					end
				end
				FMC_MODE_SC: begin
					prim_next = prim_inc;
					emb_next  = add_bit(emb_reg, sig_rise);
					per_next  = per_inc;
					if (sig_rise) begin
						per_armed_next = 1'b1;
						per_next       = '0;
						if (per_armed_reg) begin
							last_per_next = per_inc;
							seen_next     = 1'b1;
						end
					end
					if (smp_rise) begin
						// A period completing in the sample cycle counts for this sample
						ovf_next   = !(seen_reg || per_done);
						valid_next = 1'b1;
						if (avg_reg) begin
							out_prim_next = prim_inc;
							out_emb_next  = add_bit(emb_reg, sig_rise);
						end else begin
							out_prim_next = per_done ? per_inc : last_per_reg;
							out_emb_next  = {{(CNT_W-1){1'b0}}, 1'b1};
						end
						prim_next = '0;
						emb_next  = '0;
						seen_next = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			mode_reg      <= FMC_RST_MODE;
			avg_reg       <= FMC_RST_AVG;
			ext_reg       <= FMC_RST_EXT_GATE;
			div_n_reg     <= FMC_RST_DIV_N[CNT_W-1:0];
			gate_len_reg  <= FMC_RST_GATE_LEN[CNT_W-1:0];
			prim_reg      <= '0;
			emb_reg       <= '0;
			gate_cnt_reg  <= '0;
			div_cnt_reg   <= '0;
			per_reg       <= '0;
			last_per_reg  <= '0;
			armed_reg     <= 1'b0;
			per_armed_reg <= 1'b0;
			seen_reg      <= 1'b0;
			out_prim_reg  <= '0;
			out_emb_reg   <= '0;
			valid_reg     <= 1'b0;
			ovf_reg       <= 1'b0;
			gate_reg      <= 1'b0;
		end else begin
			mode_reg      <= mode_next;
			avg_reg       <= avg_next;
			ext_reg       <= ext_next;
			div_n_reg     <= div_n_next;
			gate_len_reg  <= gate_len_next;
			prim_reg      <= prim_next;
			emb_reg       <= emb_next;
			gate_cnt_reg  <= gate_cnt_next;
			div_cnt_reg   <= div_cnt_next;
			per_reg       <= per_next;
			last_per_reg  <= last_per_next;
			armed_reg     <= armed_next;
			per_armed_reg <= per_armed_next;
			seen_reg      <= seen_next;
			out_prim_reg  <= out_prim_next;
			out_emb_reg   <= out_emb_next;
			valid_reg     <= valid_next;
			ovf_reg       <= ovf_next;
			gate_reg      <= gate_next;
		end
	end

	assign o_count_primary  = out_prim_reg;
	assign o_count_embedded = out_emb_reg;
	assign o_valid          = valid_reg;
	assign o_overflow       = ovf_reg;
	assign o_gate           = gate_reg;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	sequence s_sample_tick;
		!i_cfg_load && mode_reg == FMC_MODE_SC && smp_rise;
	endsequence
	sequence s_no_period;
		!seen_reg && !per_done;
	endsequence

	a_sample_result: assert property (s_sample_tick |=> o_valid)
		else $error("sample edge gave no result");
	a_overflow_flag: assert property ((s_sample_tick and s_no_period) |=> o_overflow && o_valid)
		else $error("missing overflow on empty sample period");
	a_last_period: assert property ((s_sample_tick and !avg_reg && seen_reg && !sig_rise)
		|=> o_count_primary == $past(last_per_reg) && !o_overflow)
		else $error("non-averaged result is not the last period");
	a_avg_counts: assert property ((s_sample_tick and avg_reg)
		|=> o_count_embedded == $past(add_bit(emb_reg, sig_rise)) && o_count_primary == $past(prim_inc))
		else $error("averaged counts wrong");
	a_avg_default: assert property ($fell(i_reset) |-> avg_reg)
		else $error("averaging not enabled after reset");
	a_one_period: assert property ((!i_cfg_load && mode_reg == FMC_MODE_ONE && armed_reg && sig_rise)
		|=> o_valid && o_count_primary == $past(prim_inc))
		else $error("one-counter period not returned");
	a_hf_gate_end: assert property ((!i_cfg_load && mode_reg == FMC_MODE_HF && !ext_reg && hf_end)
		|=> o_valid && !o_gate && o_count_primary == $past(gate_len_reg))
		else $error("gate did not close at configured length");
	a_hf_gate_on: assert property ((!i_cfg_load && mode_reg == FMC_MODE_HF && !ext_reg && !hf_end)
		|=> o_gate)
		else $error("internal gate dropped inside a measurement");
	a_gate_owner: assert property (o_gate |-> $past(mode_reg) == FMC_MODE_HF)
		else $error("gate counter active outside high-frequency mode");
	a_lr_divided: assert property ((!i_cfg_load && mode_reg == FMC_MODE_LR && armed_reg && div_edge)
		|=> o_valid && o_count_embedded == $past(div_n_reg))
		else $error("divided period not returned");
	a_ext_hold: assert property ((!i_cfg_load && mode_reg == FMC_MODE_HF && ext_reg && !gate_lvl && !gate_fall)
		|=> emb_reg == $past(emb_reg))
		else $error("edges counted outside external gate");
endmodule // fmc_top

// File: test/fmc_src_model.sv
// Model of the far side: measured signal, timebase, sample clock and external gate sources.
// Assumes all pins change at the falling edge of i_mclk; period 0 holds a source low.
`timescale 1ns/1ps
module fmc_src_model (
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_sig_per,
	input  wire logic [7:0] i_smp_per,
	input  wire logic [7:0] i_gate_per,
	output logic            o_signal,
	output logic            o_timebase,
	output logic            o_sample_clk,
	output logic            o_ext_gate
);
	localparam int TB_PER = 4;
	int cyc = 0;
	int sp, ss, sg;

	// Pins settle at the first falling edge, well inside the bench's reset
	always @(negedge i_mclk) begin
		sp = int'(i_sig_per);
		ss = int'(i_smp_per);
		sg = int'(i_gate_per);
		cyc <= cyc + 1;
		// Signal, timebase and sample clock rise on different phases; the external gate rises with the timebase
		o_timebase <= (cyc % TB_PER) < (TB_PER / 2);
		o_signal <= (sp != 0) && (((cyc + sp - 1) % sp) < (sp / 2));
		o_sample_clk <= (ss != 0) && (((cyc + ss - 2) % ss) < (ss / 2));
		o_ext_gate <= (sg != 0) && ((cyc % sg) < (sg / 2));
	end
endmodule // fmc_src_model

// File: test/tb.sv
// Self-checking testbench of the frequency measure counter.
// Assumes the source model drives all pins and a timebase tick every 4 clocks.
`timescale 1ns/1ps
module tb;
	import fmc_pkg::*;

	typedef struct {
		logic [1:0]  mode;
		logic        avg;
		logic        ext;
		logic [31:0] div_n;
		logic [31:0] gate_len;
		logic [7:0]  sp;
		logic [7:0]  ss;
		logic [7:0]  sg;
		logic        chk_p;
		logic [31:0] e_p;
		logic [31:0] e_e;
	} fmc_row_t;

	logic        i_mclk = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_cfg_load = 1'b0;
	logic [1:0]  i_cfg_mode = 2'h0;
	logic        i_cfg_ext_gate = 1'b0;
	logic        i_averaging_enable = 1'b1;
	logic [31:0] i_cfg_div_n = 32'h0000_0001;
	logic [31:0] i_cfg_gate_len = 32'h0000_0001;
	logic [7:0]  sig_per = 8'h00;
	logic [7:0]  smp_per = 8'h00;
	logic [7:0]  gate_per = 8'h00;
	logic        signal, timebase, sample_clk, ext_gate;
	logic [31:0] o_count_primary, o_count_embedded;
	logic        o_valid, o_overflow, o_gate;
	int          errors = 0;
	int          tests_run = 0;

	fmc_row_t rows [7] = '{
		'{FMC_SEL_ONE, 1'b1, 1'b0, 32'h1, 32'h1, 8'h28, 8'h00, 8'h00, 1'b1, 32'hA, 32'h1},
		'{FMC_SEL_LR,  1'b1, 1'b0, 32'h3, 32'h1, 8'h08, 8'h00, 8'h00, 1'b1, 32'h6, 32'h3},
		'{FMC_SEL_LR,  1'b1, 1'b0, 32'h0, 32'h1, 8'h08, 8'h00, 8'h00, 1'b1, 32'h2, 32'h1},
		'{FMC_SEL_HF,  1'b1, 1'b0, 32'h1, 32'h5, 8'h02, 8'h00, 8'h00, 1'b1, 32'h5, 32'hA},
		'{FMC_SEL_HF,  1'b1, 1'b1, 32'h1, 32'h5, 8'h02, 8'h00, 8'h28, 1'b1, 32'h5, 32'hA},
		'{FMC_SEL_SC,  1'b1, 1'b0, 32'h1, 32'h1, 8'h08, 8'h28, 8'h00, 1'b1, 32'hA, 32'h5},
		'{FMC_SEL_SC,  1'b0, 1'b0, 32'h1, 32'h1, 8'h08, 8'h28, 8'h00, 1'b1, 32'h2, 32'h1}
	};

	always #25 i_mclk = ~i_mclk;

	fmc_src_model i_fmc_src_model (
		.i_mclk      (i_mclk),
		.i_sig_per   (sig_per),
		.i_smp_per   (smp_per),
		.i_gate_per  (gate_per),
		.o_signal    (signal),
		.o_timebase  (timebase),
		.o_sample_clk(sample_clk),
		.o_ext_gate  (ext_gate)
	);

	fmc_top #(.CNT_W(32)) i_fmc_top (
		.i_mclk            (i_mclk),
		.i_reset           (i_reset),
		.i_signal          (signal),
		.i_timebase        (timebase),
		.i_sample_clk      (sample_clk),
		.i_ext_gate        (ext_gate),
		.i_cfg_load        (i_cfg_load),
		.i_cfg_mode        (i_cfg_mode),
		.i_cfg_ext_gate    (i_cfg_ext_gate),
		.i_averaging_enable(i_averaging_enable),
		.i_cfg_div_n       (i_cfg_div_n),
		.i_cfg_gate_len    (i_cfg_gate_len),
		.o_count_primary   (o_count_primary),
		.o_count_embedded  (o_count_embedded),
		.o_valid           (o_valid),
		.o_overflow        (o_overflow),
		.o_gate            (o_gate)
	);

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// Waits for a result pulse, sampled at the falling edge
	task automatic wait_valid();
		int k;
		k = 0;
		@(negedge i_mclk);
		while (o_valid !== 1'b1 && k < 3000) begin
			@(negedge i_mclk);
			k++;
		end
		if (k >= 3000) begin
			errors++;
			$display("CHECK FAILED at %0t: no result pulse", $time);
		end
	endtask

	// Two loads back to back; the second one is the configuration in force
	task automatic load(input fmc_row_t r);
		@(negedge i_mclk);
		sig_per <= r.sp;
		smp_per <= r.ss;
		gate_per <= r.sg;
		i_cfg_mode <= FMC_SEL_ONE;
		i_cfg_load <= 1'b1;
		@(negedge i_mclk);
		i_cfg_mode <= r.mode;
		i_averaging_enable <= r.avg;
		i_cfg_ext_gate <= r.ext;
		i_cfg_div_n <= r.div_n;
		i_cfg_gate_len <= r.gate_len;
		@(negedge i_mclk);
		i_cfg_load <= 1'b0;
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#4000000;
		errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		final_report();
	end

	initial begin
		fmc_row_t r;
		repeat (20) @(negedge i_mclk);
		i_reset <= 1'b0;
		@(negedge i_mclk);
		check_val(o_count_primary, 32'h0, "primary after reset");
		check_bit(o_valid, 1'b0, "valid after reset");
		check_bit(o_overflow, 1'b0, "overflow after reset");
		check_bit(o_gate, 1'b0, "gate after reset");
		// Default configuration times one input period with no load
		sig_per <= 8'h28;
		wait_valid();
		wait_valid();
		check_val(o_count_primary, 32'hA, "default mode primary");
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			load(r);
			wait_valid();
			wait_valid();
			if (r.chk_p) begin
				check_val(o_count_primary, r.e_p, "primary");
			end
			check_val(o_count_embedded, r.e_e, "embedded");
			check_bit(o_overflow, 1'b0, "overflow");
			if (r.mode == FMC_SEL_HF && !r.ext) begin
				check_bit(o_gate, 1'b0, "gate low at result");
				@(negedge i_mclk);
				check_bit(o_gate, 1'b1, "gate open after result");
			end
			if (r.mode == FMC_SEL_HF && r.ext) begin
				check_bit(o_gate, 1'b0, "no internal gate with external gate");
			end
		end
		// Sample clock with the measured signal stopped
		r = rows[5];
		r.sp = 8'h00;
		load(r);
		wait_valid();
		wait_valid();
		check_bit(o_overflow, 1'b1, "overflow without period");
		final_report();
	end
endmodule // tb
